// *** core_ctl_pkg.sv ***
// shared constants, encodings and types of the control and indirect core
package core_ctl_pkg;

  // ==========================================================
  // widths and sizes
  localparam int IW = 14;            // instruction word
  localparam int DW = 8;             // accumulator and data bytes
  localparam int PW = 16;            // indirect pointer width
  localparam int AW = 15;            // program counter width
  localparam int STACK_DEPTH = 16;   // return stack entries
  localparam int STACK_AW = 4;
  localparam int DMEM_DEPTH = 256;   // data bytes behind the pointers
  localparam int DMEM_AW = 8;
  localparam int PIN_DIR_N = 8;      // selectable pin direction regs

  // ==========================================================
  // whole-word opcodes
  localparam logic [IW-1:0] OPC_NOP = 14'h0000;
  localparam logic [IW-1:0] OPC_SOFT_RESET = 14'h0001;
  localparam logic [IW-1:0] OPC_RETURN = 14'h0008;
  localparam logic [IW-1:0] OPC_INT_EXIT = 14'h0009;
  localparam logic [IW-1:0] OPC_INVOKE_ACC = 14'h000a;
  localparam logic [IW-1:0] OPC_JUMP_ACC = 14'h000b;
  localparam logic [IW-1:0] OPC_TIMER_CFG = 14'h0062;
  localparam logic [IW-1:0] OPC_STANDBY = 14'h0063;
  localparam logic [IW-1:0] OPC_WDT_REFRESH = 14'h0064;

  // ==========================================================
  // opcode prefixes, each compared with the top bits of the word
  localparam logic [2:0] PFX_INVOKE = 3'h4;       // bits 13:11
  localparam logic [2:0] PFX_ABS_JUMP = 3'h5;     // bits 13:11
  localparam logic [4:0] PFX_JUMP_OFF = 5'h19;    // bits 13:9
  localparam logic [5:0] PFX_EXIT_CONST = 6'h34;  // bits 13:8
  localparam logic [5:0] PFX_MASK_CONST = 6'h39;  // bits 13:8
  localparam logic [5:0] PFX_SUM_CONST = 6'h3e;   // bits 13:8
  localparam logic [5:0] PFX_MASK_FILE = 6'h05;   // bits 13:8
  localparam logic [6:0] PFX_PTR_ADD = 7'h62;     // bits 13:7
  localparam logic [6:0] PFX_IDX_LOAD = 7'h7e;    // bits 13:7
  localparam logic [6:0] PFX_IDX_STORE = 7'h7f;   // bits 13:7
  localparam logic [10:0] PFX_IND_LOAD = 11'h002;  // bits 13:3
  localparam logic [10:0] PFX_IND_STORE = 11'h003; // bits 13:3
  localparam logic [10:0] PFX_PIN_DIR = 11'h00c;   // bits 13:3

  // pre/post step modifier of the indirect moves
  localparam logic [1:0] MM_PRE_INC = 2'h0;
  localparam logic [1:0] MM_PRE_DEC = 2'h1;
  localparam logic [1:0] MM_POST_INC = 2'h2;
  localparam logic [1:0] MM_POST_DEC = 2'h3;

  // file addresses that open the indirect windows
  localparam logic [6:0] FILE_WINDOW0 = 7'h00;
  localparam logic [6:0] FILE_WINDOW1 = 7'h01;
  localparam logic [3:0] NIBBLE_MAX = 4'hf;

  // ==========================================================
  // reset values
  localparam logic [DW-1:0] ACC_RST = 8'h00;
  localparam logic [DW-1:0] TIMER_CFG_RST = 8'hff;
  localparam logic [DW-1:0] PIN_DIR_RST = 8'hff;
  localparam logic [PW-1:0] PTR_RST = 16'h0000;
  localparam logic [AW-1:0] PC_RST = 15'h0000;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,  // waiting for an instruction
    ST_EXEC = 2'b01,   // first instruction cycle
    ST_EXTRA = 2'b11,  // added cycle for the upper pointer range
    ST_FLUSH = 2'b10   // second cycle of a branch, a no-operation
  } state_t;

  typedef enum logic [4:0] {
    OP_NOP, OP_SOFT_RESET, OP_RETURN, OP_INT_EXIT, OP_INVOKE_ACC,
    OP_JUMP_ACC, OP_TIMER_CFG, OP_STANDBY, OP_WDT_REFRESH, OP_PIN_DIR,
    OP_INVOKE, OP_ABS_JUMP, OP_JUMP_OFF, OP_EXIT_CONST, OP_MASK_CONST,
    OP_SUM_CONST, OP_MASK_FILE, OP_PTR_ADD, OP_IDX_LOAD, OP_IDX_STORE,
    OP_IND_LOAD, OP_IND_STORE, OP_UNKNOWN
  } op_t;

  typedef struct packed {
    logic arith_overflow_bit;
    logic half_byte_overflow;
    logic all_bits_low_flag;
    logic watchdog_expiry_flag;
    logic power_down_flag;
  } status_t;

  localparam status_t STATUS_RST = 5'h03;  // both power flags set

  typedef struct packed {
    op_t op;                 // decoded operation
    logic ptr_sel;           // pointer n used by the operation
    logic [IW-1:0] word;     // raw instruction word
  } decoded_t;

endpackage

// *** small_ram.sv ***
// small synchronous memory with registered read data
`timescale 1ns/10ps
module small_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // write side
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side, data one edge after the address
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] cells [DEPTH];  // storage, not reset

  // write port
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= cells[rd_addr];
    end
  end

endmodule

// *** cpu_control_and_indirect_op_decode.sv ***
// decoder and executor of control, inherent and indirect instructions
`timescale 1ns/10ps

// Operation
// - taken branch spends second cycle as no-operation
// - upper-range pointer access adds one cycle
// - jump_by_accumulator: relative branch by accumulator
// - invoke_via_accumulator: call target from accumulator
// - interrupt_exit returns from service routine
// - exit_with_constant returns, loads literal
// - plain return pops address, flags untouched
// - watchdog_refresh clears watchdog, sets power flags
// - accumulator copied into timer_config_reg
// - software reset request in one cycle
// - standby request, updates power flags
// - accumulator copied into selected pin_direction_reg
// - pointer_offset_add adds sign-extended six-bit literal
// - pointer arithmetic wraps modulo sixteen bits
// - indirect_load with step, sets zero flag
// - indexed load from pointer plus offset
// - indirect_store with step, flags untouched
// - indexed store to pointer plus offset
// - mask_with_constant ANDs literal, zero flag only
// - sum_with_constant adds literal, three flags
// - mask_with_file ANDs file, chosen destination
module cpu_control_and_indirect_op_decode
  import core_ctl_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // instruction stream
  input wire logic instr_valid,
  input wire logic [IW-1:0] instr_word,
  output logic instr_ready,
  // architectural state
  output logic [DW-1:0] acc,
  output status_t status,
  output logic [AW-1:0] program_counter,
  output logic [PW-1:0] indirect_pointer0,
  output logic [PW-1:0] indirect_pointer1,
  output logic int_enable,
  // configuration written by instructions
  output logic [DW-1:0] timer_config_reg,
  output logic [PIN_DIR_N-1:0][DW-1:0] pin_direction_reg,
  // one-cycle requests to the rest of the chip
  output logic wdt_clear,
  output logic standby_req,
  output logic soft_reset_req,
  output logic unknown_op
);

  // ==========================================================
  // helpers

  // sign-extend a six-bit literal to pointer width
  function automatic logic [PW-1:0] sext6(input logic [5:0] k);
    return {{(PW-6){k[5]}}, k};
  endfunction

  // one step up or down; sixteen-bit sum wraps at both ends
  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p,
                                             input logic [1:0] mm);
    logic [PW-1:0] r;
    r = p + 16'h0001;
    if (mm == MM_PRE_DEC || mm == MM_POST_DEC) begin
      r = p - 16'h0001;
    end
    return r;
  endfunction

  // decode one instruction word
  function automatic decoded_t decode(input logic [IW-1:0] w);
    decoded_t d;
    d.word = w;
    d.ptr_sel = w[6];
    d.op = OP_UNKNOWN;
    if (w == OPC_NOP) d.op = OP_NOP;
    else if (w == OPC_SOFT_RESET) d.op = OP_SOFT_RESET;
    else if (w == OPC_RETURN) d.op = OP_RETURN;
    else if (w == OPC_INT_EXIT) d.op = OP_INT_EXIT;
    else if (w == OPC_INVOKE_ACC) d.op = OP_INVOKE_ACC;
    else if (w == OPC_JUMP_ACC) d.op = OP_JUMP_ACC;
    else if (w == OPC_TIMER_CFG) d.op = OP_TIMER_CFG;
    else if (w == OPC_STANDBY) d.op = OP_STANDBY;
    else if (w == OPC_WDT_REFRESH) d.op = OP_WDT_REFRESH;
    else if (w[13:3] == PFX_PIN_DIR) d.op = OP_PIN_DIR;
    else if (w[13:3] == PFX_IND_LOAD) d.op = OP_IND_LOAD;
    else if (w[13:3] == PFX_IND_STORE) d.op = OP_IND_STORE;
    else if (w[13:11] == PFX_INVOKE) d.op = OP_INVOKE;
    else if (w[13:11] == PFX_ABS_JUMP) d.op = OP_ABS_JUMP;
    else if (w[13:9] == PFX_JUMP_OFF) d.op = OP_JUMP_OFF;
    else if (w[13:8] == PFX_EXIT_CONST) d.op = OP_EXIT_CONST;
    else if (w[13:8] == PFX_MASK_CONST) d.op = OP_MASK_CONST;
    else if (w[13:8] == PFX_SUM_CONST) d.op = OP_SUM_CONST;
    else if (w[13:8] == PFX_MASK_FILE) d.op = OP_MASK_FILE;
    else if (w[13:7] == PFX_PTR_ADD) d.op = OP_PTR_ADD;
    else if (w[13:7] == PFX_IDX_LOAD) d.op = OP_IDX_LOAD;
    else if (w[13:7] == PFX_IDX_STORE) d.op = OP_IDX_STORE;
    // the stepped moves name their pointer in bit 2
    if (d.op == OP_IND_LOAD || d.op == OP_IND_STORE) d.ptr_sel = w[2];
    return d;
  endfunction

  // ==========================================================
  // state

  state_t state;               // sequencer
  state_t next_state;          // sequencer, next value
  decoded_t dec;               // instruction in execution
  logic [DMEM_AW-1:0] ea;      // data address of this instruction
  logic upper_range;           // pointer used has its top bit set
  logic [STACK_AW-1:0] sp;     // next free return stack slot

  // fetch-time addressing
  decoded_t fetch_dec;         // decode of the arriving word
  logic [PW-1:0] fetch_base;   // pointer named by the arriving word
  logic [PW-1:0] fetch_addr;   // data address it reaches
  logic fetch_ind;             // it goes through an indirect window
  logic accept;                // instruction taken this edge

  // memories
  logic [DW-1:0] dmem_rdata;   // data byte read at fetch
  logic dmem_we;               // data byte write in execute
  logic [DW-1:0] dmem_wdata;   // data byte to write
  logic [AW-1:0] stack_rdata;  // top of return stack
  logic stack_we;              // push in execute

  // execute-time results
  logic in_exec;               // first instruction cycle
  logic is_branch;             // instruction changes flow
  logic [DW-1:0] and_file;     // accumulator AND data byte
  logic [DW:0] sum_lit;        // accumulator plus literal
  logic [4:0] sum_nib;         // low nibble sum
  logic [PW-1:0] exec_ptr;     // pointer named by the instruction
  logic [PW-1:0] next_ptr;     // its value after execute
  logic [AW-1:0] pc_inc;       // address of the next instruction
  logic [AW-1:0] next_pc;      // program counter after execute

  assign accept = (state == ST_FETCH) && instr_valid;
  assign in_exec = (state == ST_EXEC);
  assign fetch_dec = decode(instr_word);

  // ==========================================================
  // fetch: form the data address while the memory reads it
  always_comb begin
    fetch_base = fetch_dec.ptr_sel ? indirect_pointer1 : indirect_pointer0;
    fetch_ind = 1'b0;
    fetch_addr = {9'h000, instr_word[6:0]};
    unique case (fetch_dec.op)
      OP_IND_LOAD, OP_IND_STORE: begin
        fetch_ind = 1'b1;
        fetch_addr = fetch_base;  // post step uses the old value
        if (!instr_word[1]) begin
          fetch_addr = ptr_step(fetch_base, instr_word[1:0]);
        end
      end
      OP_IDX_LOAD, OP_IDX_STORE: begin
        fetch_ind = 1'b1;
        fetch_addr = fetch_base + sext6(instr_word[5:0]);
      end
      OP_MASK_FILE: begin
        // file 0 and 1 are the two indirect windows
        if (instr_word[6:1] == FILE_WINDOW0[6:1]) begin
          fetch_ind = 1'b1;
          fetch_base = (instr_word[6:0] == FILE_WINDOW1) ?
                       indirect_pointer1 : indirect_pointer0;
          fetch_addr = fetch_base;
        end
      end
      default: begin
        fetch_ind = 1'b0;
      end
    endcase
  end

  // latch the instruction and its addressing on acceptance
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dec <= '{op: OP_NOP, ptr_sel: 1'b0, word: OPC_NOP};
      ea <= '0;
      upper_range <= 1'b0;
    end else if (accept) begin
      dec <= fetch_dec;
      ea <= fetch_addr[DMEM_AW-1:0];
      upper_range <= fetch_ind && fetch_base[PW-1];
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    is_branch = 1'b0;
    unique case (dec.op)
      OP_RETURN, OP_INT_EXIT, OP_INVOKE_ACC, OP_JUMP_ACC, OP_INVOKE,
      OP_ABS_JUMP, OP_JUMP_OFF, OP_EXIT_CONST: begin
        is_branch = 1'b1;
      end
      default: begin
        is_branch = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_FETCH: begin
        if (instr_valid) next_state = ST_EXEC;
      end
      ST_EXEC: begin
        if (upper_range) next_state = ST_EXTRA;
        else if (is_branch) next_state = ST_FLUSH;
        else next_state = ST_FETCH;
      end
      ST_EXTRA: begin
        next_state = is_branch ? ST_FLUSH : ST_FETCH;
      end
      ST_FLUSH: begin
        next_state = ST_FETCH;
      end
    endcase
  end

  // state register and ready flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_FETCH;
      instr_ready <= 1'b1;
    end else begin
      state <= next_state;
      instr_ready <= (next_state == ST_FETCH);
    end
  end

  // ==========================================================
  // datapath results of the first instruction cycle
  always_comb begin
    and_file = acc & dmem_rdata;
    sum_lit = {1'b0, acc} + {1'b0, dec.word[7:0]};
    sum_nib = {1'b0, acc[3:0]} + {1'b0, dec.word[3:0]};
    exec_ptr = dec.ptr_sel ? indirect_pointer1 : indirect_pointer0;
    next_ptr = exec_ptr;
    pc_inc = program_counter + 15'h0001;
    next_pc = pc_inc;
    unique case (dec.op)
      OP_PTR_ADD: next_ptr = exec_ptr + sext6(dec.word[5:0]);
      OP_IND_LOAD, OP_IND_STORE: begin
        next_ptr = ptr_step(exec_ptr, dec.word[1:0]);
      end
      OP_JUMP_OFF: begin
        next_pc = pc_inc + {{(AW-9){dec.word[8]}}, dec.word[8:0]};
      end
      OP_JUMP_ACC: next_pc = pc_inc + {7'h00, acc};
      OP_INVOKE_ACC: next_pc = {program_counter[14:8], acc};
      OP_INVOKE, OP_ABS_JUMP: begin
        next_pc = {program_counter[14:11], dec.word[10:0]};
      end
      OP_RETURN, OP_INT_EXIT, OP_EXIT_CONST: begin
        next_pc = stack_rdata;
      end
      default: begin
        next_ptr = exec_ptr;
      end
    endcase
  end

  // data memory write for stores and file results
  always_comb begin
    dmem_we = 1'b0;
    dmem_wdata = acc;
    if (in_exec) begin
      if (dec.op == OP_IND_STORE || dec.op == OP_IDX_STORE) begin
        dmem_we = 1'b1;
      end else if (dec.op == OP_MASK_FILE && dec.word[7]) begin
        dmem_we = 1'b1;
        dmem_wdata = and_file;
      end
    end
  end

  assign stack_we = in_exec &&
                    (dec.op == OP_INVOKE || dec.op == OP_INVOKE_ACC);

  // ==========================================================
  // accumulator
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc <= ACC_RST;
    end else if (in_exec) begin
      unique case (dec.op)
        OP_IND_LOAD, OP_IDX_LOAD: acc <= dmem_rdata;
        OP_MASK_CONST: acc <= acc & dec.word[7:0];
        OP_SUM_CONST: acc <= sum_lit[DW-1:0];
        OP_MASK_FILE: begin
          if (!dec.word[7]) acc <= and_file;
        end
        OP_EXIT_CONST: acc <= dec.word[7:0];
        default: begin
          acc <= acc;
        end
      endcase
    end
  end

  // status flags; branches, stores and pointer adds leave them alone
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status <= STATUS_RST;
    end else if (in_exec) begin
      unique case (dec.op)
        OP_IND_LOAD, OP_IDX_LOAD: begin
          status.all_bits_low_flag <= (dmem_rdata == '0);
        end
        OP_MASK_CONST: begin
          status.all_bits_low_flag <= ((acc & dec.word[7:0]) == '0);
        end
        OP_SUM_CONST: begin
          status.arith_overflow_bit <= sum_lit[DW];
          status.half_byte_overflow <= sum_nib[4];
          status.all_bits_low_flag <= (sum_lit[DW-1:0] == '0);
        end
        OP_MASK_FILE: status.all_bits_low_flag <= (and_file == '0);
        OP_WDT_REFRESH: begin
          status.watchdog_expiry_flag <= 1'b1;
          status.power_down_flag <= 1'b1;
        end
        OP_STANDBY: begin
          status.watchdog_expiry_flag <= 1'b1;
          status.power_down_flag <= 1'b0;
        end
        default: begin
          status <= status;
        end
      endcase
    end
  end

  // ==========================================================
  // program counter, return stack pointer, interrupt enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      program_counter <= PC_RST;
      sp <= '0;
      int_enable <= 1'b0;
    end else if (in_exec) begin
      program_counter <= next_pc;
      if (stack_we) sp <= sp + 4'h1;
      if (dec.op == OP_RETURN || dec.op == OP_INT_EXIT ||
          dec.op == OP_EXIT_CONST) begin
        sp <= sp - 4'h1;
      end
      if (dec.op == OP_INT_EXIT) int_enable <= 1'b1;
    end
  end

  // indirect pointers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      indirect_pointer0 <= PTR_RST;
      indirect_pointer1 <= PTR_RST;
    end else if (in_exec) begin
      if (dec.ptr_sel) indirect_pointer1 <= next_ptr;
      else indirect_pointer0 <= next_ptr;
    end
  end

  // configuration registers loaded from the accumulator
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer_config_reg <= TIMER_CFG_RST;
      pin_direction_reg <= {PIN_DIR_N{PIN_DIR_RST}};
    end else if (in_exec) begin
      if (dec.op == OP_TIMER_CFG) timer_config_reg <= acc;
      if (dec.op == OP_PIN_DIR) begin
        pin_direction_reg[dec.word[2:0]] <= acc;
      end
    end
  end

  // one-cycle requests, registered from the first instruction cycle and high in the cycle after it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wdt_clear <= 1'b0;
      standby_req <= 1'b0;
      soft_reset_req <= 1'b0;
      unknown_op <= 1'b0;
    end else begin
      wdt_clear <= in_exec && (dec.op == OP_WDT_REFRESH);
      standby_req <= in_exec && (dec.op == OP_STANDBY);
      soft_reset_req <= in_exec && (dec.op == OP_SOFT_RESET);
      unknown_op <= in_exec && (dec.op == OP_UNKNOWN);
    end
  end

  // ==========================================================
  // memories
  small_ram #(.WIDTH(DW), .DEPTH(DMEM_DEPTH), .ADDR_W(DMEM_AW)) u_dmem (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(dmem_we),
    .wr_addr(ea),
    .wr_data(dmem_wdata),
    .rd_addr(fetch_addr[DMEM_AW-1:0]),
    .rd_data(dmem_rdata)
  );

  // return stack: read slot below the pointer at fetch, pop in execute
  small_ram #(.WIDTH(AW), .DEPTH(STACK_DEPTH), .ADDR_W(STACK_AW)) u_stack (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(stack_we),
    .wr_addr(sp),
    .wr_data(pc_inc),
    .rd_addr(sp - 4'h1),
    .rd_data(stack_rdata)
  );

endmodule

// *** core_ctl_monitor.sv ***
// concurrent checks on the decoder ports
`timescale 1ns/10ps
module core_ctl_monitor
  import core_ctl_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // instruction stream
  input wire logic instr_valid,
  input wire logic [IW-1:0] instr_word,
  input wire logic instr_ready,
  // results
  input wire status_t status,
  input wire logic int_enable,
  input wire logic wdt_clear,
  input wire logic standby_req,
  input wire logic soft_reset_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // helpers
  logic take;  // word accepted at this edge
  logic flow_op;  // word that changes the program flow
  logic pls;  // watchdog, standby or soft reset request pulse
  assign take = instr_valid && instr_ready;
  assign flow_op = instr_word[13:12] == 2'b10 ||
    instr_word[13:9] == PFX_JUMP_OFF || instr_word == OPC_JUMP_ACC ||
    instr_word == OPC_INVOKE_ACC || instr_word == OPC_RETURN ||
    instr_word == OPC_INT_EXIT || instr_word[13:8] == PFX_EXIT_CONST;
  assign pls = wdt_clear || standby_req || soft_reset_req;
  // ==========================================
  // assertions
  a_branch_two_cycles: assert property (take && flow_op |=>
    !instr_ready ##1 !instr_ready ##1 instr_ready) else $error("branch");
  a_sum_one_cycle: assert property (take &&
    instr_word[13:8] == PFX_SUM_CONST |=> !instr_ready ##1 instr_ready)
    else $error("sum length");
  a_store_keeps_flags: assert property (take &&
    (instr_word[13:7] == PFX_IDX_STORE ||
    instr_word[13:3] == PFX_IND_STORE) |=> $stable(status)[*3])
    else $error("store flags");
  a_refresh_sets_flags: assert property (take &&
    instr_word == OPC_WDT_REFRESH |-> ##[1:3] (wdt_clear &&
    status.watchdog_expiry_flag && status.power_down_flag))
    else $error("refresh");
  a_standby_request: assert property (take &&
    instr_word == OPC_STANDBY |-> ##[1:3] standby_req)
    else $error("standby");
  a_soft_reset_req: assert property (take &&
    instr_word == OPC_SOFT_RESET |-> ##[1:3] soft_reset_req)
    else $error("soft reset");
  a_exit_enables_int: assert property (take &&
    instr_word == OPC_INT_EXIT |-> ##[1:3] int_enable)
    else $error("int enable");
  a_pulse_one_cycle: assert property (pls |=> !pls)
    else $error("pulse length");
  // covers
  c_branch: cover property (take && flow_op);
  c_refresh: cover property (wdt_clear);
  c_standby: cover property (standby_req);
endmodule
bind cpu_control_and_indirect_op_decode core_ctl_monitor u_mon (
  .core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
  .instr_word(instr_word), .instr_ready(instr_ready), .status(status),
  .int_enable(int_enable), .wdt_clear(wdt_clear),
  .standby_req(standby_req), .soft_reset_req(soft_reset_req));

// *** testbench.sv ***
// self-checking bench of the control and indirect decoder
`timescale 1ns/10ps
module testbench;
  import core_ctl_pkg::*;
  // ==========================================
  // block ports and counters
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [IW-1:0] instr_word = 14'h0000;
  logic instr_ready, int_enable, wdt_clear, standby_req, soft_reset_req;
  logic unknown_op;
  logic [DW-1:0] acc, timer_config_reg;
  status_t status;
  logic [AW-1:0] program_counter;
  logic [PW-1:0] indirect_pointer0, indirect_pointer1;
  logic [PIN_DIR_N-1:0][DW-1:0] pin_direction_reg;
  int n_errors = 0;
  int total_checks = 0;
  cpu_control_and_indirect_op_decode uut (.core_clk(core_clk), .rst(rst),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .acc(acc), .status(status),
    .program_counter(program_counter), .int_enable(int_enable),
    .indirect_pointer0(indirect_pointer0),
    .indirect_pointer1(indirect_pointer1),
    .timer_config_reg(timer_config_reg),
    .pin_direction_reg(pin_direction_reg), .wdt_clear(wdt_clear),
    .standby_req(standby_req), .soft_reset_req(soft_reset_req),
    .unknown_op(unknown_op));
  // clock, 5 ns period
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // ==========================================
  // tasks
  task automatic test_done();
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // offer one word, count clocks until ready returns
  task automatic op(input logic [IW-1:0] w, input int n);
    int c;
    instr_valid = 1'b1;
    instr_word = w;
    @(posedge core_clk);
    #1 instr_valid = 1'b0;
    c = 0;
    while (instr_ready !== 1'b1 && c < 8) begin
      @(posedge core_clk);
      #1 c++;
    end
    chk(16'(c), 16'(n));
  endtask
  task automatic br(input logic [IW-1:0] w, input logic [AW-1:0] t);
    op(w, 2);
    chk(16'(program_counter), 16'(t));
  endtask
  task automatic t_alu();
    chk(16'(status), 16'h0003);
    op({PFX_SUM_CONST, 8'hf8}, 1);
    op({PFX_SUM_CONST, 8'h08}, 1);
    chk(16'({acc, 3'h0, status}), 16'h001f);
    op({PFX_SUM_CONST, 8'h80}, 1);
    op({PFX_SUM_CONST, 8'h81}, 1);
    chk(16'({acc, 3'h0, status}), 16'h0113);
    op({PFX_MASK_CONST, 8'h00}, 1);
    chk(16'({acc, 3'h0, status}), 16'h0017);
  endtask
  task automatic t_mem();
    op({PFX_PTR_ADD, 1'b0, 6'h3f}, 1);
    chk(indirect_pointer0, 16'hffff);
    op({PFX_PTR_ADD, 1'b0, 6'h01}, 1);
    op({PFX_PTR_ADD, 1'b1, 6'h1f}, 1);
    chk(indirect_pointer0, 16'h0000);
    chk({indirect_pointer1[10:0], status}, 16'h03f7);
    op({PFX_SUM_CONST, 8'h5a}, 1);
    op({PFX_IND_STORE, 1'b1, MM_POST_INC}, 1);
    chk({indirect_pointer1[10:0], status}, 16'h0403);
    op({PFX_MASK_CONST, 8'h0f}, 1);
    op({PFX_IDX_STORE, 1'b1, 6'h3e}, 1);
    op({PFX_MASK_CONST, 8'h00}, 1);
    op({PFX_IND_LOAD, 1'b1, MM_PRE_DEC}, 1);
    chk({acc, 3'h0, status}, 16'h5a03);
    chk(indirect_pointer1, 16'h001f);
    op({PFX_IDX_LOAD, 1'b1, 6'h3f}, 1);
    chk(16'(acc), 16'h000a);
    op({PFX_PTR_ADD, 1'b0, 6'h3f}, 1);
    op({PFX_IND_STORE, 1'b0, MM_POST_DEC}, 2);
    op({PFX_PTR_ADD, 1'b0, 6'h01}, 1);
    op({PFX_MASK_CONST, 8'h00}, 1);
    op({PFX_IND_LOAD, 1'b0, MM_POST_INC}, 2);
    chk({acc, indirect_pointer0[7:0]}, 16'h0a00);
  endtask
  task automatic t_cfg();
    op({PFX_SUM_CONST, 8'h33}, 1);
    op({PFX_MASK_FILE, 1'b0, FILE_WINDOW1}, 1);
    chk({acc, 3'h0, status}, 16'h1803);
    op(OPC_TIMER_CFG, 1);
    chk(16'(timer_config_reg), 16'h0018);
    op({PFX_PIN_DIR, 3'h5}, 1);
    chk(pin_direction_reg[5:4], 16'h18ff);
    op(OPC_STANDBY, 1);
    chk(16'(status), 16'h0002);
    chk(16'({wdt_clear, standby_req, soft_reset_req}), 16'h0002);
    op(OPC_WDT_REFRESH, 1);
    chk(16'(status), 16'h0003);
    chk(16'({wdt_clear, standby_req, soft_reset_req}), 16'h0004);
    op(OPC_SOFT_RESET, 1);
    chk(16'({wdt_clear, standby_req, soft_reset_req}), 16'h0001);
    op(OPC_NOP, 1);
    chk(16'(unknown_op), 16'h0000);
    // a word that no rule defines runs as a no-operation and is flagged
    op(14'h0002, 1);
    chk(16'(unknown_op), 16'h0001);
    // result written back to the file, then read through the accumulator
    op({PFX_MASK_FILE, 1'b1, 7'h1e}, 1);
    chk({acc, 3'h0, status}, 16'h1803);
    op({PFX_MASK_FILE, 1'b0, 7'h1e}, 1);
    chk(16'(acc), 16'h0008);
    op({PFX_SUM_CONST, 8'h10}, 1);
  endtask
  task automatic t_branch();
    br({PFX_ABS_JUMP, 11'h123}, 15'h0123);
    br({PFX_INVOKE, 11'h200}, 15'h0200);
    br(OPC_RETURN, 15'h0124);
    br({PFX_JUMP_OFF, 9'h1fe}, 15'h0123);
    br(OPC_JUMP_ACC, 15'h013c);
    br(OPC_INVOKE_ACC, 15'h0118);
    br(OPC_INT_EXIT, 15'h013d);
    br({PFX_INVOKE, 11'h040}, 15'h0040);
    br({PFX_EXIT_CONST, 8'h77}, 15'h013e);
    chk({acc, 2'h0, int_enable, status}, 16'h7723);
  endtask
  // reset in mid-run restores every register, then work resumes
  task automatic t_reset();
    @(posedge core_clk);
    #1 rst = 1'b1;
    @(posedge core_clk);
    #1;
    chk(16'({acc, 3'h0, status}), 16'h0003);
    chk(16'(program_counter), 16'h0000);
    chk(indirect_pointer0 | indirect_pointer1, 16'h0000);
    chk({timer_config_reg, pin_direction_reg[5]}, 16'hffff);
    chk(16'({instr_ready, int_enable, unknown_op}), 16'h0004);
    rst = 1'b0;
    op(OPC_NOP, 1);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    t_alu();
    t_mem();
    t_cfg();
    t_branch();
    t_reset();
    test_done();
  end
  initial begin
    #5000;
    n_errors++;
    test_done();
  end
endmodule
